// *** logic/cfeg_control_flags.sv ***
// Control-flag register set and instruction gating unit
`timescale 1ns/100ps
module cfeg_control_flags (
	input  logic        clk,
	input  logic        rst,
	input  logic        issueValid,
	input  logic [3:0]  issueClass,
	input  logic [1:0]  issueCpl,
	input  logic        crReq,
	input  logic        crWrite,
	input  logic [3:0]  crSel,
	input  logic [31:0] crWdata,
	input  logic [1:0]  crCpl,
	input  logic        taskSwitch,
	input  logic        mcEvent,
	output logic        verdictValid_r,
	output logic        execOk_r,
	output logic        nmFault_r,
	output logic        udFault_r,
	output logic        gpFault_r,
	output logic        crDone_r,
	output logic        crGpFault_r,
	output logic [31:0] crRdata_r,
	output logic        tlbFlush_r,
	output logic        tlbKeepGlobal_r,
	output logic        mcExcept_r,
	output logic        protModeOn_r,
	output logic        pagingActive_r,
	output logic        walkCacheOff_r,
	output logic        walkWriteThru_r,
	output logic        v86Ext_r,
	output logic        protVirtIntr_r,
	output logic        largePages_r,
	output logic        widePhys_r,
	output logic        fxVectorState_r,
	output logic        dbgAlias_r
);
	logic [31:0] sysCtl_r,  sysCtl_nxt;
	logic [31:0] pageBase_r, pageBase_nxt;
	logic [31:0] extEn_r,   extEn_nxt;

	logic        decExec, decNm, decUd, decGp;
	logic        verdictValid_nxt, execOk_nxt, nmFault_nxt, udFault_nxt, gpFault_nxt;
	logic        crDone_nxt, crGpFault_nxt;
	logic [31:0] crRdata_nxt;
	logic        tlbFlush_nxt, tlbKeepGlobal_nxt, mcExcept_nxt;
	logic        protModeOn_nxt, pagingActive_nxt, walkCacheOff_nxt, walkWriteThru_nxt;
	logic        v86Ext_nxt, protVirtIntr_nxt, largePages_nxt, widePhys_nxt;
	logic        fxVectorState_nxt, dbgAlias_nxt;

	logic        pe;
	logic        crPriv;
	logic        crMapped;
	logic        badPaging;
	logic        crCommit;
	logic        clearOk;

	cfeg_gate_decode u_decode (
		.cls     (issueClass),
		.cpl     (issueCpl),
		.sysCtl  (sysCtl_r),
		.extEn   (extEn_r),
		.execOk  (decExec),
		.nmFault (decNm),
		.udFault (decUd),
		.gpFault (decGp)
	);

	assign pe        = sysCtl_r[cfeg_pkg::SYS_PROT_MODE];
	assign crPriv    = cfeg_pkg::privOk(pe, crCpl);
	assign crMapped  = (crSel == cfeg_pkg::SEL_SYS) || (crSel == cfeg_pkg::SEL_PAGE)
		|| (crSel == cfeg_pkg::SEL_EXT);
	assign badPaging = crWrite && (crSel == cfeg_pkg::SEL_SYS)
		&& crWdata[cfeg_pkg::SYS_PAGING] && !crWdata[cfeg_pkg::SYS_PROT_MODE];
	// Nothing is committed unless the access itself is clean
	assign crCommit  = crReq && crWrite && crPriv && crMapped && !badPaging;
	assign clearOk   = issueValid && (issueClass == cfeg_pkg::CLS_CLEAR_SW) && decExec;

	// Architectural control registers
	always_comb begin
		sysCtl_nxt   = sysCtl_r;
		pageBase_nxt = pageBase_r;
		extEn_nxt    = extEn_r;
		if (crCommit) begin
			case (crSel)
				cfeg_pkg::SEL_SYS:  sysCtl_nxt   = crWdata & cfeg_pkg::SYS_WMASK;
				cfeg_pkg::SEL_PAGE: pageBase_nxt = crWdata & cfeg_pkg::PB_WMASK;
				cfeg_pkg::SEL_EXT:  extEn_nxt    = crWdata & cfeg_pkg::EXT_WMASK;
				default: ;
			endcase
		end
		if (clearOk)
			sysCtl_nxt[cfeg_pkg::SYS_CTX_STALE] = 1'b0;
		// Set wins over any clear in the same cycle
		if (taskSwitch)
			sysCtl_nxt[cfeg_pkg::SYS_CTX_STALE] = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sysCtl_r   <= cfeg_pkg::SYS_RESET;
			pageBase_r <= cfeg_pkg::PB_RESET;
			extEn_r    <= cfeg_pkg::EXT_RESET;
		end else begin
			sysCtl_r   <= sysCtl_nxt;
			pageBase_r <= pageBase_nxt;
			extEn_r    <= extEn_nxt;
		end
	end

	// Verdicts, register answers and events
	always_comb begin
		verdictValid_nxt  = issueValid;
		execOk_nxt        = issueValid && decExec;
		nmFault_nxt       = issueValid && decNm;
		udFault_nxt       = issueValid && decUd;
		gpFault_nxt       = issueValid && decGp;
		crDone_nxt        = crReq;
		crGpFault_nxt     = crReq && !(crPriv && crMapped && !badPaging);
		crRdata_nxt       = 32'h0000_0000;
		if (crReq && !crWrite && crPriv) begin
			case (crSel)
				cfeg_pkg::SEL_SYS:  crRdata_nxt = sysCtl_r;
				cfeg_pkg::SEL_PAGE: crRdata_nxt = pageBase_r;
				cfeg_pkg::SEL_EXT:  crRdata_nxt = extEn_r;
				default:            crRdata_nxt = 32'h0000_0000;
			endcase
		end
		tlbFlush_nxt      = taskSwitch || (crCommit && crSel == cfeg_pkg::SEL_PAGE);
		tlbKeepGlobal_nxt = extEn_r[cfeg_pkg::EXT_GLOBAL_PG];
		mcExcept_nxt      = mcEvent && extEn_r[cfeg_pkg::EXT_MCHK_ON];
	end

	// Decoded mode flags, one cycle behind the registers
	always_comb begin
		protModeOn_nxt    = pe;
		pagingActive_nxt  = pe && sysCtl_r[cfeg_pkg::SYS_PAGING];
		walkCacheOff_nxt  = pagingActive_nxt && !extEn_r[cfeg_pkg::EXT_WIDE_PHYS]
			&& !extEn_r[cfeg_pkg::EXT_CTX_ID] && pageBase_r[cfeg_pkg::PB_CACHE_OFF];
		walkWriteThru_nxt = pagingActive_nxt && !extEn_r[cfeg_pkg::EXT_WIDE_PHYS]
			&& !extEn_r[cfeg_pkg::EXT_CTX_ID] && pageBase_r[cfeg_pkg::PB_WRITE_THRU];
		v86Ext_nxt        = extEn_r[cfeg_pkg::EXT_V86];
		protVirtIntr_nxt  = pe && extEn_r[cfeg_pkg::EXT_PROT_VIF];
		largePages_nxt    = extEn_r[cfeg_pkg::EXT_LARGE_PAGE];
		widePhys_nxt      = extEn_r[cfeg_pkg::EXT_WIDE_PHYS];
		fxVectorState_nxt = extEn_r[cfeg_pkg::EXT_FX_SUPPORT];
		dbgAlias_nxt      = !extEn_r[cfeg_pkg::EXT_DBG_TRAP];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			verdictValid_r  <= 1'b0;
			execOk_r        <= 1'b0;
			nmFault_r       <= 1'b0;
			udFault_r       <= 1'b0;
			gpFault_r       <= 1'b0;
			crDone_r        <= 1'b0;
			crGpFault_r     <= 1'b0;
			crRdata_r       <= 32'h0000_0000;
			tlbFlush_r      <= 1'b0;
			tlbKeepGlobal_r <= 1'b0;
			mcExcept_r      <= 1'b0;
			protModeOn_r    <= 1'b0;
			pagingActive_r  <= 1'b0;
			walkCacheOff_r  <= 1'b0;
			walkWriteThru_r <= 1'b0;
			v86Ext_r        <= 1'b0;
			protVirtIntr_r  <= 1'b0;
			largePages_r    <= 1'b0;
			widePhys_r      <= 1'b0;
			fxVectorState_r <= 1'b0;
			dbgAlias_r      <= 1'b1;
		end else begin
			verdictValid_r  <= verdictValid_nxt;
			execOk_r        <= execOk_nxt;
			nmFault_r       <= nmFault_nxt;
			udFault_r       <= udFault_nxt;
			gpFault_r       <= gpFault_nxt;
			crDone_r        <= crDone_nxt;
			crGpFault_r     <= crGpFault_nxt;
			crRdata_r       <= crRdata_nxt;
			tlbFlush_r      <= tlbFlush_nxt;
			tlbKeepGlobal_r <= tlbKeepGlobal_nxt;
			mcExcept_r      <= mcExcept_nxt;
			protModeOn_r    <= protModeOn_nxt;
			pagingActive_r  <= pagingActive_nxt;
			walkCacheOff_r  <= walkCacheOff_nxt;
			walkWriteThru_r <= walkWriteThru_nxt;
			v86Ext_r        <= v86Ext_nxt;
			protVirtIntr_r  <= protVirtIntr_nxt;
			largePages_r    <= largePages_nxt;
			widePhys_r      <= widePhys_nxt;
			fxVectorState_r <= fxVectorState_nxt;
			dbgAlias_r      <= dbgAlias_nxt;
		end
	end

	default clocking cbk @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_fpIssue;
		issueValid && issueClass == cfeg_pkg::CLS_FPU;
	endsequence

	sequence s_switchThenFp;
		taskSwitch ##1 s_fpIssue;
	endsequence

	property p_fpGate;
		s_fpIssue |=> (nmFault_r == ($past(sysCtl_r[cfeg_pkg::SYS_NO_FPU])
			|| $past(sysCtl_r[cfeg_pkg::SYS_CTX_STALE]))) && (execOk_r != nmFault_r);
	endproperty
	a_fpGate: assert property (p_fpGate) else $error("fp gating wrong");

	property p_waitGate;
		issueValid && issueClass == cfeg_pkg::CLS_WAIT |=> execOk_r == !($past(
			sysCtl_r[cfeg_pkg::SYS_WAIT_WATCH]) && $past(sysCtl_r[cfeg_pkg::SYS_CTX_STALE]));
	endproperty
	a_waitGate: assert property (p_waitGate) else $error("wait gating wrong");

	property p_switchFaults;
		s_switchThenFp |=> nmFault_r && !execOk_r;
	endproperty
	a_switchFaults: assert property (p_switchFaults) else $error("no fault after switch");

	property p_clearStale;
		clearOk && !taskSwitch |=> !sysCtl_r[cfeg_pkg::SYS_CTX_STALE] ##0 execOk_r;
	endproperty
	a_clearStale: assert property (p_clearStale) else $error("stale not cleared");

	property p_packedUd;
		issueValid && issueClass == cfeg_pkg::CLS_PACKED && sysCtl_r[cfeg_pkg::SYS_NO_FPU]
			|=> udFault_r && !nmFault_r;
	endproperty
	a_packedUd: assert property (p_packedUd) else $error("packed op not invalid");

	property p_streamGate;
		issueValid && issueClass == cfeg_pkg::CLS_STREAM |=> udFault_r == ($past(
			sysCtl_r[cfeg_pkg::SYS_NO_FPU]) || !$past(extEn_r[cfeg_pkg::EXT_FX_SUPPORT]));
	endproperty
	a_streamGate: assert property (p_streamGate) else $error("stream gating wrong");

	property p_exemptRuns;
		issueValid && issueClass == cfeg_pkg::CLS_STREAM_EXEMPT |=> execOk_r;
	endproperty
	a_exemptRuns: assert property (p_exemptRuns) else $error("exempt op faulted");

	property p_cycleRead;
		issueValid && issueClass == cfeg_pkg::CLS_CYCLE_RD |=> gpFault_r == ($past(
			extEn_r[cfeg_pkg::EXT_CYCLE_PRIV]) && $past(pe) && $past(issueCpl) != 2'h0);
	endproperty
	a_cycleRead: assert property (p_cycleRead) else $error("cycle read gating wrong");

	property p_badPaging;
		crReq && badPaging |=> crGpFault_r && $stable(sysCtl_r);
	endproperty
	a_badPaging: assert property (p_badPaging) else $error("paging without prot");

	property p_crPriv;
		crReq && pe && crCpl != 2'h0 |=> crGpFault_r && crRdata_r == 32'h0000_0000
			&& $stable(extEn_r) && $stable(pageBase_r);
	endproperty
	a_crPriv: assert property (p_crPriv) else $error("user reached control reg");

	property p_mcheck;
		mcEvent |=> mcExcept_r == $past(extEn_r[cfeg_pkg::EXT_MCHK_ON]);
	endproperty
	a_mcheck: assert property (p_mcheck) else $error("machine check gating wrong");

	property p_globalKeep;
		crCommit && crSel == cfeg_pkg::SEL_PAGE |=> tlbFlush_r
			&& tlbKeepGlobal_r == $past(extEn_r[cfeg_pkg::EXT_GLOBAL_PG]);
	endproperty
	a_globalKeep: assert property (p_globalKeep) else $error("tlb flush wrong");

endmodule // cfeg_control_flags

// *** logic/cfeg_pkg.sv ***
// Shared constants and types for the control-flag execution gating block
package cfeg_pkg;

	localparam int          XLEN            = 32;

	// System control register fields
	localparam int          SYS_PROT_MODE   = 0;
	localparam int          SYS_WAIT_WATCH  = 1;
	localparam int          SYS_NO_FPU      = 2;
	localparam int          SYS_CTX_STALE   = 3;
	localparam int          SYS_PAGING      = 31;

	// Paging base register fields
	localparam int          PB_WRITE_THRU   = 3;
	localparam int          PB_CACHE_OFF    = 4;

	// Extension enable register fields
	localparam int          EXT_V86         = 0;
	localparam int          EXT_PROT_VIF    = 1;
	localparam int          EXT_CYCLE_PRIV  = 2;
	localparam int          EXT_DBG_TRAP    = 3;
	localparam int          EXT_LARGE_PAGE  = 4;
	localparam int          EXT_WIDE_PHYS   = 5;
	localparam int          EXT_MCHK_ON     = 6;
	localparam int          EXT_GLOBAL_PG   = 7;
	localparam int          EXT_PERF_ANY    = 8;
	localparam int          EXT_FX_SUPPORT  = 9;
	localparam int          EXT_CTX_ID      = 17;

	// Implemented bits; all others read as zero and ignore writes
	localparam logic [31:0] SYS_WMASK       = 32'h8000_000F;
	localparam logic [31:0] PB_WMASK        = 32'hFFFF_F018;
	localparam logic [31:0] EXT_WMASK       = 32'h0002_03FF;

	localparam logic [31:0] SYS_RESET       = 32'h0000_0000;
	localparam logic [31:0] PB_RESET        = 32'h0000_0000;
	localparam logic [31:0] EXT_RESET       = 32'h0000_0000;

	// Control register selectors
	localparam logic [3:0]  SEL_SYS         = 4'h0;
	localparam logic [3:0]  SEL_PAGE        = 4'h3;
	localparam logic [3:0]  SEL_EXT         = 4'h4;

	localparam logic [1:0]  CPL_KERNEL      = 2'h0;

	typedef enum logic [3:0] {
		CLS_NONE,
		CLS_FPU,
		CLS_WAIT,
		CLS_FXSTATE,
		CLS_PACKED,
		CLS_STREAM,
		CLS_STREAM_EXEMPT,
		CLS_CYCLE_RD,
		CLS_PERF_RD,
		CLS_DBG_REF45,
		CLS_CLEAR_SW
	} cfeg_class_t;

	// Privileged work is allowed in real mode or at level 0
	function automatic logic privOk(input logic protMode, input logic [1:0] cpl);
		return !protMode || (cpl == CPL_KERNEL);
	endfunction

endpackage

// *** logic/cfeg_gate_decode.sv ***
// Combinational verdict for one instruction class against current flags
`timescale 1ns/100ps
module cfeg_gate_decode (
	input  logic [3:0]  cls,
	input  logic [1:0]  cpl,
	input  logic [31:0] sysCtl,
	input  logic [31:0] extEn,
	output logic        execOk,
	output logic        nmFault,
	output logic        udFault,
	output logic        gpFault
);
	logic pe;
	logic noFpu;
	logic stale;
	logic waitWatch;

	assign pe        = sysCtl[cfeg_pkg::SYS_PROT_MODE];
	assign noFpu     = sysCtl[cfeg_pkg::SYS_NO_FPU];
	assign stale     = sysCtl[cfeg_pkg::SYS_CTX_STALE];
	assign waitWatch = sysCtl[cfeg_pkg::SYS_WAIT_WATCH];

	// Invalid opcode outranks unavailable device
	always_comb begin
		nmFault = 1'b0;
		udFault = 1'b0;
		gpFault = 1'b0;
		case (cls)
			cfeg_pkg::CLS_FPU,
			cfeg_pkg::CLS_FXSTATE: nmFault = noFpu || stale;
			cfeg_pkg::CLS_WAIT: nmFault = waitWatch && stale;
			cfeg_pkg::CLS_PACKED: begin
				udFault = noFpu;
				nmFault = !noFpu && stale;
			end
			cfeg_pkg::CLS_STREAM: begin
				udFault = noFpu || !extEn[cfeg_pkg::EXT_FX_SUPPORT];
				nmFault = !udFault && stale;
			end
			cfeg_pkg::CLS_STREAM_EXEMPT: ;
			cfeg_pkg::CLS_CYCLE_RD:
				gpFault = extEn[cfeg_pkg::EXT_CYCLE_PRIV] && !cfeg_pkg::privOk(pe, cpl);
			cfeg_pkg::CLS_PERF_RD:
				gpFault = !extEn[cfeg_pkg::EXT_PERF_ANY] && !cfeg_pkg::privOk(pe, cpl);
			cfeg_pkg::CLS_DBG_REF45: begin
				gpFault = !cfeg_pkg::privOk(pe, cpl);
				udFault = !gpFault && extEn[cfeg_pkg::EXT_DBG_TRAP];
			end
			cfeg_pkg::CLS_CLEAR_SW: gpFault = !cfeg_pkg::privOk(pe, cpl);
			default: ;
		endcase
		execOk = !(nmFault || udFault || gpFault);
	end

endmodule // cfeg_gate_decode

// *** testbench/control_flag_exec_gating_test.sv ***
// Self-checking bench for the control-flag gating unit
`timescale 1ns/100ps
module control_flag_exec_gating_test;
	logic        clk;
	logic        rst;
	logic        issueValid;
	logic [3:0]  issueClass;
	logic [1:0]  issueCpl;
	logic        crReq;
	logic        crWrite;
	logic [3:0]  crSel;
	logic [31:0] crWdata;
	logic [1:0]  crCpl;
	logic        taskSwitch;
	logic        mcEvent;
	logic        verdictValid_r, execOk_r, nmFault_r, udFault_r, gpFault_r;
	logic        crDone_r, crGpFault_r, tlbFlush_r, tlbKeepGlobal_r, mcExcept_r;
	logic [31:0] crRdata_r;
	logic        protModeOn_r, pagingActive_r, walkCacheOff_r, walkWriteThru_r, v86Ext_r;
	logic        protVirtIntr_r, largePages_r, widePhys_r, fxVectorState_r, dbgAlias_r;
	logic [10:0] lvls;
	logic [31:0] sys, pb, ext, seed;
	int          errorCnt, comparisons;

	cfeg_control_flags dut (.clk, .rst, .issueValid, .issueClass, .issueCpl, .crReq,
		.crWrite, .crSel, .crWdata, .crCpl, .taskSwitch, .mcEvent, .verdictValid_r,
		.execOk_r, .nmFault_r, .udFault_r, .gpFault_r, .crDone_r, .crGpFault_r,
		.crRdata_r, .tlbFlush_r, .tlbKeepGlobal_r, .mcExcept_r, .protModeOn_r,
		.pagingActive_r, .walkCacheOff_r, .walkWriteThru_r, .v86Ext_r, .protVirtIntr_r,
		.largePages_r, .widePhys_r, .fxVectorState_r, .dbgAlias_r);

	assign lvls = {protModeOn_r, pagingActive_r, walkCacheOff_r, walkWriteThru_r, v86Ext_r,
		protVirtIntr_r, largePages_r, widePhys_r, fxVectorState_r, dbgAlias_r, tlbKeepGlobal_r};

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errorCnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic finishTest();
		$display("TB: errors %0d comparisons %0d", errorCnt, comparisons);
		if (errorCnt == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [10:0] expLvl();
		logic pgOn;
		logic walk;
		pgOn = sys[0] & sys[31];
		walk = pgOn & !ext[5] & !ext[17];
		return {sys[0], pgOn, walk & pb[4], walk & pb[3], ext[0], sys[0] & ext[1], ext[4],
			ext[5], ext[9], !ext[3], ext[7]};
	endfunction

	// Verdict as {valid, exec, nm, ud, gp}; privilege wins over opcode over unavailable
	function automatic logic [4:0] expVerdict(input logic [3:0] c, input logic [1:0] cpl);
		logic       po;
		logic [1:0] f;
		po = !sys[0] || cpl == 2'h0;
		f = 2'h0;
		case (c)
			cfeg_pkg::CLS_FPU, cfeg_pkg::CLS_FXSTATE: if (sys[2] | sys[3]) f = 2'h1;
			cfeg_pkg::CLS_WAIT: if (sys[1] & sys[3]) f = 2'h1;
			cfeg_pkg::CLS_PACKED: f = sys[2] ? 2'h2 : {1'h0, sys[3]};
			cfeg_pkg::CLS_STREAM: f = (sys[2] | !ext[9]) ? 2'h2 : {1'h0, sys[3]};
			cfeg_pkg::CLS_CYCLE_RD: if (ext[2] & !po) f = 2'h3;
			cfeg_pkg::CLS_PERF_RD: if (!ext[8] & !po) f = 2'h3;
			cfeg_pkg::CLS_DBG_REF45: f = !po ? 2'h3 : {ext[3], 1'h0};
			cfeg_pkg::CLS_CLEAR_SW: if (!po) f = 2'h3;
			default: f = 2'h0;
		endcase
		return {1'h1, f == 2'h0, f == 2'h1, f == 2'h2, f == 2'h3};
	endfunction

	// Level outputs trail the registers by one cycle, so look one edge later
	task automatic settle();
		@(posedge clk);
		#1;
		chk("levels", 32'(lvls), 32'(expLvl()));
	endtask

	task automatic cr(input logic w, input logic [3:0] sel, input logic [31:0] d,
		input logic [1:0] cpl);
		logic        gp;
		logic [31:0] rd;
		gp = (sys[0] && cpl != 2'h0) || !(sel inside {cfeg_pkg::SEL_SYS, cfeg_pkg::SEL_PAGE,
			cfeg_pkg::SEL_EXT}) || (w && sel == cfeg_pkg::SEL_SYS && d[31] && !d[0]);
		rd = 32'h0;
		if (!gp && !w)
			rd = sel == cfeg_pkg::SEL_SYS ? sys : (sel == cfeg_pkg::SEL_PAGE ? pb : ext);
		@(posedge clk);
		crReq <= 1'h1;
		crWrite <= w;
		crSel <= sel;
		crWdata <= d;
		crCpl <= cpl;
		@(posedge clk);
		crReq <= 1'h0;
		#1;
		chk("crDone", 32'(crDone_r), 32'h1);
		chk("crGpFault", 32'(crGpFault_r), 32'(gp));
		chk("crRdata", crRdata_r, rd);
		chk("tlbFlush", 32'(tlbFlush_r), 32'(w && !gp && sel == cfeg_pkg::SEL_PAGE));
		if (w && !gp) begin
			if (sel == cfeg_pkg::SEL_SYS) sys = d & cfeg_pkg::SYS_WMASK;
			if (sel == cfeg_pkg::SEL_PAGE) pb = d & cfeg_pkg::PB_WMASK;
			if (sel == cfeg_pkg::SEL_EXT) ext = d & cfeg_pkg::EXT_WMASK;
		end
		settle();
	endtask

	task automatic issue(input logic [3:0] c, input logic [1:0] cpl);
		logic [4:0] e;
		e = expVerdict(c, cpl);
		@(posedge clk);
		issueValid <= 1'h1;
		issueClass <= c;
		issueCpl <= cpl;
		@(posedge clk);
		issueValid <= 1'h0;
		#1;
		chk("verdict", 32'({verdictValid_r, execOk_r, nmFault_r, udFault_r, gpFault_r}),
			32'(e));
		if (c == cfeg_pkg::CLS_CLEAR_SW && e[3]) sys[3] = 1'h0;
		settle();
	endtask

	task automatic evt(input logic sw);
		@(posedge clk);
		if (sw) taskSwitch <= 1'h1;
		else mcEvent <= 1'h1;
		@(posedge clk);
		taskSwitch <= 1'h0;
		mcEvent <= 1'h0;
		#1;
		if (sw) begin
			chk("tlbFlush", 32'(tlbFlush_r), 32'h1);
			sys[3] = 1'h1;
		end else
			chk("mcExcept", 32'(mcExcept_r), 32'(ext[6]));
		settle();
	endtask

	// Floating-point op in the very cycle after a task switch must see stale set
	task automatic swFp();
		logic [4:0] e;
		@(posedge clk);
		taskSwitch <= 1'h1;
		@(posedge clk);
		taskSwitch <= 1'h0;
		issueValid <= 1'h1;
		issueClass <= cfeg_pkg::CLS_FPU;
		issueCpl <= 2'h0;
		sys[3] = 1'h1;
		e = expVerdict(cfeg_pkg::CLS_FPU, 2'h0);
		@(posedge clk);
		issueValid <= 1'h0;
		#1;
		chk("switchFp", 32'({verdictValid_r, execOk_r, nmFault_r, udFault_r, gpFault_r}),
			32'(e));
		settle();
	endtask

	initial begin
		logic [31:0] r;
		logic [3:0]  s;
		logic [31:0] d;
		{rst, issueValid, issueClass, issueCpl, crReq, crWrite} = '0;
		{crSel, crWdata, crCpl, taskSwitch, mcEvent} = '0;
		{sys, pb, ext, errorCnt, comparisons} = '0;
		rst = 1'h1;
		seed = 32'h3EB0E621;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		settle();
		cr(1'h0, cfeg_pkg::SEL_SYS, 32'h0, 2'h0);
		cr(1'h0, cfeg_pkg::SEL_PAGE, 32'h0, 2'h0);
		cr(1'h0, cfeg_pkg::SEL_EXT, 32'h0, 2'h0);
		cr(1'h0, 4'h7, 32'h0, 2'h0);
		cr(1'h1, cfeg_pkg::SEL_SYS, 32'h8000_0000, 2'h0);
		for (int i = 0; i < 8; i++) begin
			cr(1'h1, cfeg_pkg::SEL_SYS, 32'(i << 1), 2'h0);
			issue(cfeg_pkg::CLS_FPU, 2'h0);
			issue(cfeg_pkg::CLS_WAIT, 2'h0);
		end
		for (int k = 0; k < 2; k++) begin
			// Paging goes on before the extension register is written (global pages on in pass 0, off in pass 1)
			cr(1'h1, cfeg_pkg::SEL_SYS, 32'h8000_0009, 2'h0);
			cr(1'h1, cfeg_pkg::SEL_EXT, k ? 32'h0 : 32'hFFFF_FFFF, 2'h0);
			cr(1'h1, cfeg_pkg::SEL_PAGE, 32'hFFFF_FFFF, 2'h0);
			cr(1'h0, cfeg_pkg::SEL_SYS, 32'h0, 2'h3);
			for (int c = 0; c < 11; c++) begin
				issue(4'(c), 2'h3);
				issue(4'(c), 2'h0);
			end
			evt(1'h1);
			swFp();
			evt(1'h0);
			cr(1'h1, cfeg_pkg::SEL_SYS, 32'h0, 2'h0);
		end
		repeat (400) begin
			r = rnd();
			s = r[5:4] == 2'h0 ? cfeg_pkg::SEL_SYS : (r[5:4] == 2'h1 ? cfeg_pkg::SEL_PAGE :
				(r[5:4] == 2'h2 ? cfeg_pkg::SEL_EXT : r[11:8]));
			case (r[2:0])
				3'h0, 3'h1: begin
					d = rnd();
					if (!(sys[0] && sys[31])) d[7] = 1'h0;
					cr(r[3], s, d, r[7:6]);
				end
				3'h5: evt(1'h1);
				3'h6: evt(1'h0);
				3'h7: cr(1'h1, cfeg_pkg::SEL_SYS, rnd() & 32'h7FFF_FFFF, 2'h0);
				default: issue(r[15:12] % 4'hB, r[17:16]);
			endcase
		end
		finishTest();
	end

	// Whole run needs about 1500 cycles
	initial begin
		#200000;
		errorCnt++;
		finishTest();
	end
endmodule // control_flag_exec_gating_test
